// ===== rtl/lmcd_decoder.sv
// Command decoder and lost-communication supervisor
`timescale 1ns/100ps
`include "lmcd_params.svh"
module lmcd_decoder #(
  parameter int LOST_FRAMES = `LMCD_LOST_FRAMES
) (
  input  wire logic               i_clk_sys,       // System clock
  input  wire logic               i_rst,           // Sync reset
  input  wire logic               i_frame_valid,   // Frame strobe
  input  wire lmcd_pkg::lmcd_frame_t i_frame,      // Frame content
  input  wire logic               i_sleep_frame,   // Type 1 sleep frame
  input  wire logic [7:0]         i_prep_byte1,    // Type 8 first data byte
  input  wire logic               i_frame_tick,    // Frame-time pulse
  input  wire logic [6:0]         i_node_addr,     // Own physical address
  input  wire logic               i_hw_addr_float, // Hardwired address float
  input  wire logic               i_half_step,     // Half-step mode
  input  wire logic [10:0]        i_safe_point,    // RAM safe point
  input  wire logic               i_move_done,     // Positioner finished
  output lmcd_pkg::lmcd_act_t     o_act,           // Action pulses
  output logic                    o_reply_pending, // Prepared read armed
  output logic [6:0]              o_reply_cmd,     // Prepared read code
  output logic                    o_zero_origin,   // Load zero to position
  output logic                    o_abs_move,      // Start absolute move
  output logic [10:0]             o_target_position, // Safe target
  output logic                    o_motor_power,   // Motor powered
  output logic                    o_sleep,         // Sleep state
  output logic                    o_lost           // Communication lost
);
  ////////////////////////////////////////////////////////////////////
  logic        float_s1_q;
  logic        float_s2_q;
  logic        lost_w;
  logic        full_seen_q;
  logic        addr_ok;
  logic        is_prep;
  logic        is_read6;
  logic        act_ok;
  logic [6:0]  code;
  lmcd_pkg::lmcd_act_t act_d;
  lmcd_pkg::lmcd_state_t state_q;

  // Floating pin is asynchronous, double sample first
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      float_s1_q <= 1'b0;
      float_s2_q <= 1'b0;
    end else begin
      float_s1_q <= i_hw_addr_float;
      float_s2_q <= float_s1_q;
    end
  end

  lmcd_lost_timer #(
    .LOST_FRAMES (LOST_FRAMES)
  ) u_lmcd_lost_timer (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_frame_tick (i_frame_tick),
    .i_valid      (i_frame_valid),
    .o_lost       (lost_w)
  );

  ////////////////////////////////////////////////////////////////////
  // Slot decode, used by both address check and command mapping
  function automatic logic [6:0] slot_code(input logic [3:0] s);
    case (s)
      `LMCD_SLOT_READ_POS:    slot_code = `LMCD_CMD_READ_POS;
      `LMCD_SLOT_READ_SHORT:  slot_code = `LMCD_CMD_READ_SHORT;
      `LMCD_SLOT_MOVE_TARGET: slot_code = `LMCD_CMD_MOVE_TARGET;
      `LMCD_SLOT_SHORT_1:     slot_code = `LMCD_CMD_SHORT_1;
      `LMCD_SLOT_SHORT_2:     slot_code = `LMCD_CMD_SHORT_2;
      `LMCD_SLOT_SHORT_4:     slot_code = `LMCD_CMD_SHORT_4;
      default:                slot_code = 7'h7F;
    endcase
  endfunction

  function automatic logic slot_addressed(input logic [3:0] s);
    // Low three id bits carry the node, hence at most eight nodes
    slot_addressed = (s == `LMCD_SLOT_READ_POS) || (s == `LMCD_SLOT_READ_SHORT) ||
                     (s == `LMCD_SLOT_MOVE_TARGET);
  endfunction

  always_comb begin
    code = i_frame.by_slot ? slot_code(i_frame.slot) : i_frame.cmd;
    // Broadcast 0 ignores address field
    addr_ok = !i_frame.has_broad || !i_frame.broad ||
              (i_frame.addr == i_node_addr);
    if (i_frame.by_slot && slot_addressed(i_frame.slot)) begin
      addr_ok = (i_frame.addr[2:0] == i_node_addr[2:0]);
    end
    is_prep = (i_frame.ftype == 4'h7) ||
              (i_frame.ftype == 4'h8 && i_prep_byte1 == `LMCD_APP_MARKER);
    is_read6 = (i_frame.ftype == 4'h6);
    act_ok = i_frame_valid && addr_ok && state_q != lmcd_pkg::LMCD_SLEEP;
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    act_d = '0;
    // Dynamic-id frames carry no code field, the slot names the command
    if (act_ok && (i_frame.has_cmd || i_frame.by_slot)) begin
      case (code)
        `LMCD_CMD_READ_SHORT:
          act_d.read_short_state_cmd = (i_frame.ftype == 4'h5);
        `LMCD_CMD_READ_POS:
          act_d.read_position_cmd = (i_frame.ftype == 4'h5) && i_frame.by_slot;
        `LMCD_CMD_GO_SAFE:
          act_d.go_safe_point_cmd = (i_frame.ftype == 4'h1);
        `LMCD_CMD_HALT_NOW:
          act_d.immediate_halt_cmd = (i_frame.ftype == 4'h1);
        `LMCD_CMD_DECEL_HALT:
          act_d.decel_halt_cmd = (i_frame.ftype == 4'h1);
        `LMCD_CMD_ZERO_ORIGIN:
          act_d.zero_origin_cmd = (i_frame.ftype == 4'h1);
        `LMCD_CMD_RAM_DEFAULTS:
          act_d.ram_defaults_cmd = (i_frame.ftype == 4'h1);
        `LMCD_CMD_TWO_STAGE:
          act_d.two_stage_move_cmd = (i_frame.ftype == 4'h4);
        `LMCD_CMD_MOTION_PARAMS:
          act_d.load_motion_params_cmd = (i_frame.ftype == 4'h4);
        `LMCD_CMD_FUSE_OTP:
          act_d.fuse_otp_byte_cmd = (i_frame.ftype == 4'h4);
        `LMCD_CMD_MOVE_TARGET:
          act_d.move_target_cmd = (i_frame.ftype == 4'h1) || (i_frame.ftype == 4'h3) ||
                                  (i_frame.ftype == 4'h4);
        `LMCD_CMD_SHORT_1, `LMCD_CMD_SHORT_2, `LMCD_CMD_SHORT_4:
          act_d.short_move_cmd = (i_frame.ftype == 4'h2) && i_half_step;
        default: act_d = '0;
      endcase
    end
    // Prepared reads are released by the type 6 frame that follows
    if (i_frame_valid && is_read6 && o_reply_pending) begin
      act_d.read_position_cmd   = (o_reply_cmd == `LMCD_CMD_READ_POS);
      act_d.read_full_state_cmd = (o_reply_cmd == `LMCD_CMD_READ_FULL);
      act_d.read_otp_cmd        = (o_reply_cmd == `LMCD_CMD_READ_OTP);
    end
    if (act_ok && i_sleep_frame && i_frame.ftype == 4'h1) begin
      act_d.sleep_cmd = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_act <= '0;
    end else begin
      o_act <= act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Any frame after a preparing frame consumes the armed read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reply_pending <= 1'b0;
      o_reply_cmd     <= 7'h00;
    end else if (i_frame_valid) begin
      o_reply_pending <= act_ok && is_prep && i_frame.has_cmd &&
                         (i_frame.cmd == `LMCD_CMD_READ_POS ||
                          i_frame.cmd == `LMCD_CMD_READ_FULL ||
                          i_frame.cmd == `LMCD_CMD_READ_OTP);
      o_reply_cmd     <= i_frame.cmd;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_zero_origin <= 1'b0;
    end else begin
      o_zero_origin <= act_d.zero_origin_cmd;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      full_seen_q <= 1'b0;
    end else if (act_d.read_full_state_cmd) begin
      full_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_lost <= 1'b0;
    end else begin
      o_lost <= lost_w || float_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= lmcd_pkg::LMCD_SHUTDOWN;
    end else begin
      case (state_q)
        lmcd_pkg::LMCD_SHUTDOWN:
          if (full_seen_q && !o_lost) begin
            state_q <= lmcd_pkg::LMCD_NORMAL;
          end
        lmcd_pkg::LMCD_NORMAL:
          if (o_lost) begin
            if (i_safe_point == `LMCD_SAFE_NONE) begin
              state_q <= lmcd_pkg::LMCD_SLEEP;
            end else begin
              state_q <= lmcd_pkg::LMCD_SAFE_GO;
            end
          end else if (act_d.sleep_cmd) begin
            state_q <= lmcd_pkg::LMCD_SLEEP;
          end
        lmcd_pkg::LMCD_SAFE_GO:
          state_q <= lmcd_pkg::LMCD_SAFE_WT;
        lmcd_pkg::LMCD_SAFE_WT:
          if (i_move_done) begin
            state_q <= lmcd_pkg::LMCD_SLEEP;
          end
        lmcd_pkg::LMCD_SLEEP:
          state_q <= lmcd_pkg::LMCD_SLEEP;
        default:
          state_q <= lmcd_pkg::LMCD_SHUTDOWN;
      endcase
    end
  end

  // RAM value, eleven bits, latched when secure move starts
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_target_position <= 11'h000;
      o_abs_move        <= 1'b0;
    end else begin
      o_abs_move <= (state_q == lmcd_pkg::LMCD_SAFE_GO);
      if (state_q == lmcd_pkg::LMCD_SAFE_GO) begin
        o_target_position <= i_safe_point;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_motor_power <= 1'b0;
      o_sleep       <= 1'b0;
    end else begin
      o_motor_power <= (state_q == lmcd_pkg::LMCD_NORMAL) ||
                       (state_q == lmcd_pkg::LMCD_SAFE_GO) ||
                       (state_q == lmcd_pkg::LMCD_SAFE_WT);
      o_sleep       <= (state_q == lmcd_pkg::LMCD_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////
  property p_shutdown_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == lmcd_pkg::LMCD_SHUTDOWN) |=> !o_motor_power;
  endproperty
  a_shutdown_hold : assert property (p_shutdown_hold)
    else $error("motor powered in shutdown");

  property p_skip_safe;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == lmcd_pkg::LMCD_NORMAL && o_lost && i_safe_point == `LMCD_SAFE_NONE)
      |=> ##1 o_sleep && !o_abs_move;
  endproperty
  a_skip_safe : assert property (p_skip_safe)
    else $error("no direct sleep on empty safe point");

  property p_safe_move;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == lmcd_pkg::LMCD_SAFE_GO) |=> o_abs_move &&
      o_target_position == $past(i_safe_point);
  endproperty
  a_safe_move : assert property (p_safe_move)
    else $error("safe move target wrong");

  property p_zero;
    @(posedge i_clk_sys) disable iff (i_rst)
      (act_ok && i_frame.has_cmd && code == `LMCD_CMD_ZERO_ORIGIN && i_frame.ftype == 4'h1)
      |=> o_zero_origin && o_act.zero_origin_cmd;
  endproperty
  a_zero : assert property (p_zero)
    else $error("zero origin not issued");

  property p_full_in6;
    @(posedge i_clk_sys) disable iff (i_rst)
      o_act.read_full_state_cmd |-> $past(is_read6 && i_frame_valid && o_reply_pending);
  endproperty
  a_full_in6 : assert property (p_full_in6)
    else $error("full status outside type 6");

  property p_short_half;
    @(posedge i_clk_sys) disable iff (i_rst)
      o_act.short_move_cmd |-> $past(i_half_step) && $past(i_frame.ftype) == 4'h2;
  endproperty
  a_short_half : assert property (p_short_half)
    else $error("short move outside half step");

  property p_short_direct;
    @(posedge i_clk_sys) disable iff (i_rst)
      (act_ok && (i_frame.has_cmd || i_frame.by_slot) && code == `LMCD_CMD_READ_SHORT &&
       i_frame.ftype == 4'h5) |=> o_act.read_short_state_cmd;
  endproperty
  a_short_direct : assert property (p_short_direct)
    else $error("short status not answered directly");

  property p_addr_drop;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_frame_valid && i_frame.has_broad && i_frame.broad && !i_frame.by_slot &&
       i_frame.addr != i_node_addr) |=> o_act == '0;
  endproperty
  a_addr_drop : assert property (p_addr_drop)
    else $error("foreign command acted on");

  property p_sleep_cmd;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == lmcd_pkg::LMCD_NORMAL && !o_lost && act_d.sleep_cmd) |=> ##1 o_sleep;
  endproperty
  a_sleep_cmd : assert property (p_sleep_cmd)
    else $error("sleep command ignored");

  c_safe   : cover property (@(posedge i_clk_sys) state_q == lmcd_pkg::LMCD_SAFE_WT ##2 o_sleep);
  c_prep   : cover property (@(posedge i_clk_sys) o_act.read_full_state_cmd);
  c_direct : cover property (@(posedge i_clk_sys) $rose(o_sleep) && !o_abs_move);
endmodule

// ===== rtl/lmcd_params.svh
// Constants for the motor command decoder
`ifndef LMCD_PARAMS_SVH
`define LMCD_PARAMS_SVH
`define LMCD_CMD_READ_POS      7'h00
`define LMCD_CMD_READ_FULL     7'h01
`define LMCD_CMD_READ_OTP      7'h02
`define LMCD_CMD_READ_SHORT    7'h03
`define LMCD_CMD_GO_SAFE       7'h04
`define LMCD_CMD_HALT_NOW      7'h05
`define LMCD_CMD_ZERO_ORIGIN   7'h06
`define LMCD_CMD_RAM_DEFAULTS  7'h07
`define LMCD_CMD_TWO_STAGE     7'h08
`define LMCD_CMD_MOTION_PARAMS 7'h09
`define LMCD_CMD_MOVE_TARGET   7'h0B
`define LMCD_CMD_SHORT_1       7'h0C
`define LMCD_CMD_SHORT_2       7'h0D
`define LMCD_CMD_SHORT_4       7'h0E
`define LMCD_CMD_DECEL_HALT    7'h0F
`define LMCD_CMD_FUSE_OTP      7'h10
`define LMCD_APP_MARKER        8'h80
`define LMCD_SLOT_GP2          4'h0
`define LMCD_SLOT_GP4          4'h1
`define LMCD_SLOT_READ_POS     4'h2
`define LMCD_SLOT_READ_SHORT   4'h3
`define LMCD_SLOT_MOVE_TARGET  4'h4
`define LMCD_SLOT_SHORT_1      4'h5
`define LMCD_SLOT_SHORT_2      4'h6
`define LMCD_SLOT_SHORT_4      4'h7
`define LMCD_SLOT_PREPARE      4'h8
`define LMCD_SLOT_COUNT        9
`define LMCD_SAFE_NONE         11'h400
`define LMCD_LOST_FRAMES       25000
`define LMCD_ADDR_W            7
`endif

// ===== rtl/lmcd_pkg.sv
// Types shared by the motor command decoder
package lmcd_pkg;
  // Incoming frame, already checked by the LIN link layer
  typedef struct packed {
    logic [3:0] ftype;      // Frame type 1..8
    logic [6:0] cmd;        // Command code
    logic [6:0] addr;       // Physical address field
    logic       broad;      // Broadcast bit, 0 = all nodes
    logic       has_broad;  // Frame carries a broadcast bit
    logic       has_cmd;    // Command code field valid
    logic [3:0] slot;       // Command slot pointer of dynamic id
    logic       by_slot;    // Frame reached us through dynamic id
  } lmcd_frame_t;

  // Decoded action strobes
  typedef struct packed {
    logic read_position_cmd;
    logic read_full_state_cmd;
    logic read_otp_cmd;
    logic read_short_state_cmd;
    logic go_safe_point_cmd;
    logic immediate_halt_cmd;
    logic decel_halt_cmd;
    logic zero_origin_cmd;
    logic ram_defaults_cmd;
    logic two_stage_move_cmd;
    logic load_motion_params_cmd;
    logic fuse_otp_byte_cmd;
    logic move_target_cmd;
    logic short_move_cmd;
    logic sleep_cmd;
  } lmcd_act_t;

  typedef enum logic [4:0] {
    LMCD_SHUTDOWN = 5'b00001,
    LMCD_NORMAL   = 5'b00010,
    LMCD_SAFE_GO  = 5'b00100,
    LMCD_SAFE_WT  = 5'b01000,
    LMCD_SLEEP    = 5'b10000
  } lmcd_state_t;
endpackage

// ===== rtl/lmcd_lost_timer.sv
// Counter of frame times without valid bus traffic
`timescale 1ns/100ps
`include "lmcd_params.svh"
module lmcd_lost_timer #(
  parameter int LOST_FRAMES = `LMCD_LOST_FRAMES
) (
  input  wire logic i_clk_sys,   // System clock
  input  wire logic i_rst,       // Sync reset
  input  wire logic i_frame_tick, // One pulse per frame time
  input  wire logic i_valid,     // Valid frame seen
  output logic      o_lost       // Communication lost, sticky
);
  logic [15:0] cnt_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= 16'h0000;
    end else if (i_valid) begin
      cnt_q <= 16'h0000;
    end else if (i_frame_tick && !o_lost) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // A valid frame arriving in the same cycle blocks the set
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_lost <= 1'b0;
    end else if (i_frame_tick && !i_valid && cnt_q == 16'(LOST_FRAMES - 1)) begin
      o_lost <= 1'b1;
    end
  end

  property p_lost_count;
    @(posedge i_clk_sys) disable iff (i_rst)
      $rose(o_lost) |-> $past(cnt_q) == 16'(LOST_FRAMES - 1);
  endproperty
  a_lost_count : assert property (p_lost_count)
    else $error("lost flag set at wrong count");
endmodule

// ===== testbench/lmcd_master_model.sv
// Frame source standing in for the bus master and its link layer
`timescale 1ns/100ps
module lmcd_master_model (
  input  wire logic                  i_clk_sys,     // System clock
  input  wire logic                  i_rst,         // Sync reset
  input  wire logic                  i_send,        // Frame request from bench
  input  wire lmcd_pkg::lmcd_frame_t i_frame,       // Frame to deliver
  input  wire logic                  i_sleep,       // Frame is the sleep frame
  input  wire logic [7:0]            i_byte1,       // First data byte
  input  wire logic                  i_tick_en,     // Frame slots elapse
  output logic                       o_frame_valid, // Frame strobe
  output lmcd_pkg::lmcd_frame_t      o_frame,       // Frame content
  output logic                       o_sleep_frame, // Sleep frame marker
  output logic [7:0]                 o_prep_byte1,  // First data byte
  output logic                       o_frame_tick   // Frame-time pulse
);
  lmcd_pkg::lmcd_frame_t last_q;
  logic [7:0]            byte_q;
  logic [1:0]            slot_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Between frames show inverted old content, never a stale copy
  assign o_frame_valid = i_send;
  assign o_frame       = i_send ? i_frame : ~last_q;
  assign o_prep_byte1  = i_send ? i_byte1 : ~byte_q;
  assign o_sleep_frame = i_send & i_sleep;
  assign o_frame_tick  = i_tick_en & (slot_q == 2'h3);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      last_q <= '0;
      byte_q <= 8'h00;
    end else if (i_send) begin
      last_q <= i_frame;
      byte_q <= i_byte1;
    end
  end

  // One frame time every four clocks keeps the loss runs short
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      slot_q <= 2'h0;
    end else begin
      slot_q <= slot_q + 2'h1;
    end
  end
endmodule

// ===== testbench/tb_top.sv
// Self-checking testbench for the motor command decoder
`timescale 1ns/100ps
module tb_top;
  localparam logic [6:0] NODE = 7'h15;
  // Rows: frame type, command code, expected action bit (10 means none)
  localparam logic [19:0] TBL [0:15] = '{
    20'h1_06_07, 20'h1_05_09, 20'h1_0F_08, 20'h1_07_06, 20'h4_08_05, 20'h4_09_04,
    20'h4_10_03, 20'h1_0B_02, 20'h3_0B_02, 20'h4_0B_02, 20'h2_0C_01, 20'h2_0D_01,
    20'h2_0E_01, 20'h5_03_0B, 20'h1_08_10, 20'h1_04_0A};

  logic                  clk, rst, snd, slp, tick_en, flt, half, mdone;
  logic [10:0]           safe;
  logic [7:0]            b1, db1;
  lmcd_pkg::lmcd_frame_t fr, dfr;
  lmcd_pkg::lmcd_act_t   act;
  logic                  fv, dslp, tick, rp, zo, am, mp, sl, lost;
  logic [6:0]            rc;
  logic [10:0]           tp;
  logic [3:0]            obs;
  int                    n_errors, cmp_count, n_move;

  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  assign obs = {lost, am, sl, mp};
  always @(posedge clk) begin
    if (am === 1'b1) begin
      n_move++;
    end
  end

  lmcd_master_model u_lmcd_master_model (.i_clk_sys(clk), .i_rst(rst), .i_send(snd),
    .i_frame(fr), .i_sleep(slp), .i_byte1(b1), .i_tick_en(tick_en), .o_frame_valid(fv),
    .o_frame(dfr), .o_sleep_frame(dslp), .o_prep_byte1(db1), .o_frame_tick(tick));

  lmcd_decoder #(.LOST_FRAMES(8)) u_lmcd_decoder (.i_clk_sys(clk), .i_rst(rst),
    .i_frame_valid(fv), .i_frame(dfr), .i_sleep_frame(dslp), .i_prep_byte1(db1),
    .i_frame_tick(tick), .i_node_addr(NODE), .i_hw_addr_float(flt), .i_half_step(half),
    .i_safe_point(safe), .i_move_done(mdone), .o_act(act), .o_reply_pending(rp),
    .o_reply_cmd(rc), .o_zero_origin(zo), .o_abs_move(am), .o_target_position(tp),
    .o_motor_power(mp), .o_sleep(sl), .o_lost(lost));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic lmcd_pkg::lmcd_frame_t mk(input logic [3:0] t, input logic [6:0] c,
                                               input logic [6:0] a, input logic bc);
    lmcd_pkg::lmcd_frame_t f;
    f = '{ftype: t, cmd: c, addr: a, broad: bc, has_broad: 1'b1, has_cmd: 1'b1,
          slot: 4'h0, by_slot: 1'b0};
    return f;
  endfunction

  // Action pulses are looked at in the one cycle they stand
  task automatic send(input lmcd_pkg::lmcd_frame_t f, input logic s, input logic [7:0] b);
    @(posedge clk);
    snd <= 1'b1;
    fr  <= f;
    slp <= s;
    b1  <= b;
    @(posedge clk);
    snd <= 1'b0;
    #1;
  endtask

  task automatic wait_for(input int idx, input int lim);
    int k;
    k = 0;
    while (obs[idx] !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(16'(obs[idx]), 16'h0001);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst     <= 1'b1;
    tick_en <= 1'b0;
    flt     <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic go_normal;
    send(mk(4'h7, 7'h01, NODE, 1'b1), 1'b0, 8'h00);
    chk(16'({rp, rc}), 16'h0081);
    send(mk(4'h6, 7'h00, NODE, 1'b1), 1'b0, 8'h00);
    chk(16'(act), 16'h2000);
    wait_for(0, 20);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; snd = 1'b0; slp = 1'b0; tick_en = 1'b0; flt = 1'b0; half = 1'b1;
    mdone = 1'b0; safe = 11'h123; b1 = 8'h00; fr = '0;
    do_reset();
    go_normal();
    foreach (TBL[i]) begin
      send(mk(TBL[i][19:16], TBL[i][14:8], NODE, 1'b1), 1'b0, 8'h00);
      chk(16'(act), 16'h0001 << TBL[i][7:0]);
      chk(16'(zo), 16'(TBL[i][7:0] == 8'h07));
    end
    half <= 1'b0;
    send(mk(4'h2, 7'h0C, NODE, 1'b1), 1'b0, 8'h00);
    chk(16'(act), 16'h0000);
    foreach (TBL[i]) begin
      if (i < 2) begin
        send(mk(4'h8, 7'(i * 2), NODE, 1'b1), 1'b0, 8'h80);
        chk(16'(rp), 16'h0001);
        send(mk(4'h6, 7'h00, NODE, 1'b1), 1'b0, 8'h00);
        chk(16'(act), (i == 0) ? 16'h4000 : 16'h1000);
      end
    end
    send(mk(4'h8, 7'h00, NODE, 1'b1), 1'b0, 8'h00);
    chk(16'(rp), 16'h0000);
    send(mk(4'h1, 7'h05, NODE ^ 7'h01, 1'b1), 1'b0, 8'h00);
    chk(16'(act), 16'h0000);
    send(mk(4'h1, 7'h05, NODE ^ 7'h01, 1'b0), 1'b0, 8'h00);
    chk(16'(act), 16'h0200);
    fr <= mk(4'h5, 7'h00, {4'hA, NODE[2:0]}, 1'b1);
    @(posedge clk);
    send('{ftype: 4'h5, cmd: 7'h00, addr: {4'hA, NODE[2:0]}, broad: 1'b1, has_broad: 1'b0,
           has_cmd: 1'b0, slot: 4'h3, by_slot: 1'b1}, 1'b0, 8'h00);
    chk(16'(act), 16'h0800);
    send(mk(4'h1, 7'h00, NODE, 1'b1), 1'b1, 8'h00);
    chk(16'(act), 16'h0001);
    wait_for(1, 10);
    send(mk(4'h1, 7'h05, NODE, 1'b1), 1'b0, 8'h00);
    chk(16'(act), 16'h0000);
    $display("test commands done");

    do_reset();
    go_normal();
    tick_en <= 1'b1;
    wait_for(3, 200);
    wait_for(2, 10);
    chk(16'(tp), 16'h0123);
    chk(16'(sl), 16'h0000);
    @(posedge clk);
    mdone <= 1'b1;
    @(posedge clk);
    mdone <= 1'b0;
    wait_for(1, 10);
    $display("test secure move done");

    do_reset();
    safe <= 11'h400;
    go_normal();
    n_move = 0;
    flt <= 1'b1;
    wait_for(3, 10);
    wait_for(1, 10);
    chk(16'(n_move), 16'h0000);
    $display("test direct sleep done");

    do_reset();
    tick_en <= 1'b1;
    wait_for(3, 200);
    repeat (20) @(posedge clk);
    #1;
    chk(16'({mp, sl}), 16'h0000);
    $display("test startup loss done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
